// file: rtl/sync_event_map.svh
// Register offsets, field positions and timing counts for the sync and content logic
`ifndef SYNC_EVENT_MAP_SVH
`define SYNC_EVENT_MAP_SVH
`define PERIODIC_SYNC_INTERVAL_OFF 12'h0d4
`define COMMAND_CONTROL_OFF 12'h100
`define STATUS_OFF 12'h104
`define LUT_EVENT_TYPE_OFF 12'h200
`define LUT_PARTITION_TYPE_OFF 12'h240
`define SYNC_ENABLE_BIT 31
`define FORCE_SYNC_BIT 20
`define BLOCK_LEVEL_RESET 8'h01
`define SHORT_BUSY_NS 3000
`define CLOCK_PERIOD_NS 10
`define SHORT_BUSY_CYCLES (`SHORT_BUSY_NS / `CLOCK_PERIOD_NS)
`define CONTENT_MARKER 4'h7
`define STROBE_MARKER 4'h9
`define SYNC_TYPE_CODE 2'h3
`define ACK_COUNT_WIDTH 8
`endif

// file: rtl/sync_event_pkg.sv
// Types shared by both ends of the trigger/busy link
package sync_event_pkg;
  typedef enum logic [1:0] {
    dev_run,
    dev_short_busy,
    dev_wait_release
  } dev_state_t;
  typedef logic [15:0] link_word_t;
  typedef logic [7:0] event_type_t;
endpackage

// file: rtl/trigger_link_if.sv
// Trigger word link and busy return between the central unit and interface boards
`timescale 1ns/1ps
`default_nettype none
interface trigger_link_if;
  logic [15:0] link_word;
  logic link_valid;
  logic [3:0] board_busy;
  logic [3:0] readout_ack;
  modport central_trigger_unit (output link_word, output link_valid, input board_busy);
  modport frontend_interface_board (input link_word, input link_valid, output board_busy,
    input readout_ack);
endinterface
`default_nettype wire

// file: rtl/central_trigger_unit.sv
// Central trigger unit: sync generation, trigger pause, content words, type lookup
//
// Summary of operation
// - Periodic mode marks last event every Nth block
// - Block level up to 255 events
// - Interval N and enable at periodic_sync_interval
// - Periodic sync keeps the original event type
// - Forced sync inserts extra event, type zero
// - Bit 20 at command_control forces sync
// - Front panel input also makes sync
// - After sync, 3 us busy blocks triggers
// - Boards raise busy and set marker
// - Board busy arrives within 3 us
// - Board releases busy on final acknowledge
// - Resume only after all boards release busy
// - Counters continue across the sync pause
// - Content word follows strobe, marker 0111
// - Bits 11:8 branch flags, 7:0 local count
// - At most one readout trigger per 32 ns; not enforced, trigger_in is taken on any dev_run cycle
// - Board decodes content into event word 4
// - Eight lookup cells each, fixed combination
// - Type code 11 in bits 9:8 marks sync
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "sync_event_map.svh"
module central_trigger_unit
  import sync_event_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Trigger sources
  input wire logic trigger_in,
  input wire logic [7:0] trigger_inputs,
  input wire logic [3:0] local_trigger,
  input wire logic [3:0] branch_match,
  input wire logic front_panel_sync,
  input wire logic buffer_mode,
  // Status
  output logic trigger_accepted,
  output logic [31:0] event_number,
  // Link
  trigger_link_if.central_trigger_unit link
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [15:0] sync_interval;
  logic sync_enable;
  logic [7:0] block_level;
  logic [7:0] lut_event [0:7];
  logic [7:0] lut_part [0:7];
  logic aw_held, w_held;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic force_pulse;
  dev_state_t state;
  logic [8:0] busy_count;
  logic [7:0] event_in_block;
  logic [15:0] block_count;
  logic [31:0] trigger_time;
  logic [7:0] local_count;
  logic [3:0] branch_flags;
  logic content_pending;
  logic [15:0] pending_content;
  logic front_panel_q;
  logic sync_request;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire do_write = aw_held && w_held && !s_axi_bvalid;
  wire hit_interval = aw_addr == `PERIODIC_SYNC_INTERVAL_OFF;
  wire hit_command = aw_addr == `COMMAND_CONTROL_OFF;
  wire hit_lut_e = aw_addr[11:5] == 7'(`LUT_EVENT_TYPE_OFF >> 5);
  wire hit_lut_p = aw_addr[11:5] == 7'(`LUT_PARTITION_TYPE_OFF >> 5);
  wire [2:0] lut_idx = aw_addr[4:2];
  wire [2:0] rd_idx = s_axi_araddr[4:2];
  wire rd_lut_e = s_axi_araddr[11:5] == 7'(`LUT_EVENT_TYPE_OFF >> 5);
  wire rd_lut_p = s_axi_araddr[11:5] == 7'(`LUT_PARTITION_TYPE_OFF >> 5);
  wire rd_known = rd_lut_e || rd_lut_p || s_axi_araddr == `PERIODIC_SYNC_INTERVAL_OFF ||
    s_axi_araddr == `COMMAND_CONTROL_OFF || s_axi_araddr == `STATUS_OFF;
  wire [31:0] rd_value =
    rd_lut_e ? {24'h000000, lut_event[rd_idx]} :
    rd_lut_p ? {24'h000000, lut_part[rd_idx]} :
    s_axi_araddr == `PERIODIC_SYNC_INTERVAL_OFF ?
      {sync_enable, 7'h00, block_level, sync_interval} :
    s_axi_araddr == `STATUS_OFF ? {28'h0000000, link.board_busy == 4'h0, 1'b0, state} :
    32'h00000000;

  // ----------------------------------------
  // Event type lookup and trigger path
  // ----------------------------------------
  wire [7:0] type_a = lut_event[trigger_inputs[2:0]];
  wire [7:0] type_b = lut_event[{1'b1, trigger_inputs[4:3]}];
  wire [7:0] part_type = lut_part[trigger_inputs[7:5]];
  wire [7:0] event_type = (type_a | type_b) ^ part_type;
  wire can_trigger = state == dev_run;
  wire take = trigger_in && can_trigger;
  wire last_in_block = event_in_block >= block_level - 8'h01;
  wire periodic_sync = sync_enable && take && last_in_block &&
    block_count >= sync_interval - 16'h0001;
  wire forced = can_trigger && !take && sync_request;
  wire fp_rise = front_panel_sync && !front_panel_q;
  wire [1:0] type_code = periodic_sync || forced ? `SYNC_TYPE_CODE : 2'h1;
  wire [5:0] strobe_type = forced ? 6'h00 : event_type[7:2];
  wire [15:0] strobe_word = {`STROBE_MARKER, trigger_time[1:0], type_code, 2'h0, strobe_type};
  wire [7:0] next_local = local_count + {7'h00, |local_trigger};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 12'h000;
      w_data <= 32'h00000000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
      sync_interval <= 16'h0001;
      sync_enable <= 1'b0;
      block_level <= `BLOCK_LEVEL_RESET;
      force_pulse <= 1'b0;
      for (int i = 0; i < 8; i++) begin
        lut_event[i] <= 8'h00;
        lut_part[i] <= 8'h00;
      end
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
      end
      force_pulse <= 1'b0;
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (hit_interval || hit_command || hit_lut_e || hit_lut_p) ? 2'h0 : 2'h2;
        if (hit_interval) begin
          sync_interval <= w_data[15:0] == 16'h0000 ? 16'h0001 : w_data[15:0];
          block_level <= w_data[23:16] == 8'h00 ? 8'h01 : w_data[23:16];
          sync_enable <= w_data[`SYNC_ENABLE_BIT];
        end
        if (hit_command)
          force_pulse <= w_data[`FORCE_SYNC_BIT];
        if (hit_lut_e)
          lut_event[lut_idx] <= w_data[7:0];
        if (hit_lut_p)
          lut_part[lut_idx] <= w_data[7:0];
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_value;
        s_axi_rresp <= rd_known ? 2'h0 : 2'h2;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Sync control and link words
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= dev_run;
      busy_count <= 9'h000;
      event_in_block <= 8'h00;
      block_count <= 16'h0000;
      trigger_time <= 32'h00000000;
      event_number <= 32'h00000000;
      local_count <= 8'h00;
      branch_flags <= 4'h0;
      content_pending <= 1'b0;
      pending_content <= 16'h0000;
      front_panel_q <= 1'b0;
      sync_request <= 1'b0;
      trigger_accepted <= 1'b0;
      link.link_word <= 16'h0000;
      link.link_valid <= 1'b0;
    end else begin
      front_panel_q <= front_panel_sync;
      trigger_time <= trigger_time + 32'h00000001;
      if (force_pulse || fp_rise)
        sync_request <= 1'b1;
      else if (forced)
        sync_request <= 1'b0;
      branch_flags <= branch_flags | (local_trigger & branch_match);
      local_count <= next_local;
      trigger_accepted <= take || forced;
      link.link_valid <= 1'b1;
      if (take || forced) begin
        event_number <= event_number + 32'h00000001;
        link.link_word <= strobe_word;
        content_pending <= buffer_mode;
        pending_content <= {`CONTENT_MARKER, branch_flags | (local_trigger & branch_match),
          next_local};
        branch_flags <= 4'h0;
        local_count <= 8'h00;
      end else if (content_pending) begin
        link.link_word <= pending_content;
        content_pending <= 1'b0;
      end else begin
        link.link_word <= {4'h4, trigger_time[13:2]};
      end
      if (take) begin
        if (last_in_block) begin
          event_in_block <= 8'h00;
          block_count <= periodic_sync ? 16'h0000 : block_count + 16'h0001;
        end else begin
          event_in_block <= event_in_block + 8'h01;
        end
      end
      case (state)
        dev_run: begin
          if (periodic_sync || forced) begin
            state <= dev_short_busy;
            busy_count <= 9'(`SHORT_BUSY_CYCLES - 1);
          end
        end
        dev_short_busy: begin
          if (busy_count == 9'h000)
            state <= dev_wait_release;
          else
            busy_count <= busy_count - 9'h001;
        end
        dev_wait_release: begin
          if (link.board_busy == 4'h0)
            state <= dev_run;
        end
        default: state <= dev_run;
      endcase
    end
  end
endmodule
`default_nettype wire

// file: rtl/frontend_interface_board.sv
// Interface board end: sync busy, polling marker and content-word decode
`timescale 1ns/1ps
`default_nettype none
`include "sync_event_map.svh"
module frontend_interface_board
  import sync_event_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Readout side
  input wire logic [3:0] block_pending,
  output logic [3:0] sync_marker,
  output logic [3:0] trigger_out,
  output logic [11:0] event_word4_high,
  output logic event_word4_valid,
  // Link
  trigger_link_if.frontend_interface_board link
);
  // ----------------------------------------
  // Per-board state
  // ----------------------------------------
  logic [3:0] sync_busy;
  logic [`ACK_COUNT_WIDTH-1:0] outstanding [0:3];
  wire is_strobe = link.link_valid && link.link_word[15:12] == `STROBE_MARKER;
  wire is_sync = is_strobe && link.link_word[9:8] == `SYNC_TYPE_CODE;
  wire is_content = link.link_valid && link.link_word[15:12] == `CONTENT_MARKER;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_busy <= 4'h0;
      sync_marker <= 4'h0;
      trigger_out <= 4'h0;
      event_word4_high <= 12'h000;
      event_word4_valid <= 1'b0;
      link.board_busy <= 4'h0;
      for (int i = 0; i < 4; i++)
        outstanding[i] <= '0;
    end else begin
      trigger_out <= is_strobe && link.link_word[9:8] != 2'h0 ? 4'hf : 4'h0;
      event_word4_valid <= is_content;
      if (is_content)
        event_word4_high <= link.link_word[11:0];
      for (int i = 0; i < 4; i++) begin
        if (is_sync) begin
          sync_busy[i] <= 1'b1;
          sync_marker[i] <= 1'b1;
          outstanding[i] <= block_pending[i] ? 8'h02 : 8'h01;
        end else if (sync_busy[i] && link.readout_ack[i]) begin
          if (outstanding[i] <= 8'h01) begin
            sync_busy[i] <= 1'b0;
            sync_marker[i] <= 1'b0;
          end
          outstanding[i] <= outstanding[i] - 8'h01;
        end else if (sync_busy[i] && block_pending[i] && outstanding[i] == 8'h01) begin
          outstanding[i] <= 8'h02;
        end
      end
      link.board_busy <= sync_busy | (is_sync ? 4'hf : 4'h0);
    end
  end
endmodule
`default_nettype wire

// file: tb/sync_event_chk.sv
// Assertions on the trigger link between the central unit and the boards
`timescale 1ns/1ps
`default_nettype none
module sync_event_chk (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Link
  input wire logic [15:0] link_word,
  input wire logic link_valid,
  input wire logic [3:0] board_busy,
  input wire logic [3:0] readout_ack
);
  // ----------------
  // Helpers
  // ----------------
  logic [8:0] gap;
  wire logic strobe = link_word[15:12] == 4'h9;
  wire logic sync_strobe = strobe && link_word[9:8] == 2'h3;
  wire logic time_word = link_word[15:12] == 4'h4;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gap <= 9'h1ff;
    end else if (sync_strobe) begin
      gap <= 9'h000;
    end else if (gap != 9'h1ff) begin
      gap <= gap + 9'h001;
    end
  end
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ----------------
  // Properties
  // ----------------
  sync_busy_a: assert property (sync_strobe |=> board_busy == 4'hf)
    else $error("boards not busy after sync strobe");
  busy_cause_a: assert property (|(board_busy & ~$past(board_busy)) |-> $past(sync_strobe))
    else $error("board busy without sync strobe");
  busy_blocks_a: assert property (|board_busy |=> !strobe)
    else $error("strobe while boards busy");
  short_busy_a: assert property (strobe |-> gap >= 9'h12a)
    else $error("strobe inside short busy");
  content_after_a: assert property (link_word[15:12] == 4'h7 |-> $past(strobe))
    else $error("content word not after strobe");
  busy_release_a: assert property (
    (~board_busy & $past(board_busy) & ~$past(readout_ack, 2)) == 4'h0)
    else $error("busy released without acknowledge");
  time_steady_a: assert property (time_word && $past(time_word) |->
    12'(link_word[11:0] - $past(link_word[11:0])) <= 12'h001)
    else $error("time word jumped");
  link_alive_a: assert property ($past(aresetn, 2) |-> link_valid)
    else $error("link not valid");
  cover property (sync_strobe);
  cover property (link_word[15:12] == 4'h7);
  cover property (|(board_busy & ~readout_ack) && |readout_ack);
endmodule
`default_nettype wire

// file: tb/test_sync_event_trigger_content_gen.sv
// Testbench for the central trigger unit and the interface boards
`timescale 1ns/1ps
`default_nettype none
module test_sync_event_trigger_content_gen;
  typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] q; logic [1:0] r;} row_t;
  row_t rows [6] = '{'{12'h0d4, 32'h00ff_ffff, 32'h00ff_ffff, 2'h0},
    '{12'h0d4, 32'h0002_0003, 32'h0002_0003, 2'h0}, '{12'h100, 32'h0, 32'h0, 2'h0},
    '{12'h200, 32'h5a, 32'h5a, 2'h0}, '{12'h240, 32'h0f, 32'h0f, 2'h0},
    '{12'h0f0, 32'h1234_5678, 32'h0, 2'h2}};
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
  logic arready, rvalid, trigger_in, front_panel_sync, trigger_accepted, ew4_valid;
  logic [11:0] awaddr, araddr, ew4_high, ew4;
  logic [31:0] wdata, rdata, event_number, q;
  logic [1:0] bresp, rresp, r;
  logic [3:0] local_trigger, block_pending, sync_marker, trigger_out, trig_seen;
  logic [15:0] last_str, cw;
  int n_errors = 0;
  int n_tests = 0;
  int n_str = 0;
  int n_acc = 0;
  int n_cw = 0;
  logic [7:0] trigger_inputs;
  logic buffer_mode;
  int a0;
  trigger_link_if trigger_link_if_i ();
  central_trigger_unit central_trigger_unit_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .trigger_in(trigger_in), .trigger_inputs(trigger_inputs), .local_trigger(local_trigger),
    .branch_match(4'h5), .front_panel_sync(front_panel_sync), .buffer_mode(buffer_mode),
    .trigger_accepted(trigger_accepted), .event_number(event_number),
    .link(trigger_link_if_i));
  frontend_interface_board frontend_interface_board_i (.aclk(aclk), .aresetn(aresetn),
    .block_pending(block_pending), .sync_marker(sync_marker), .trigger_out(trigger_out),
    .event_word4_high(ew4_high), .event_word4_valid(ew4_valid), .link(trigger_link_if_i));
  sync_event_chk sync_event_chk_i (.aclk(aclk), .aresetn(aresetn),
    .link_word(trigger_link_if_i.link_word), .link_valid(trigger_link_if_i.link_valid),
    .board_busy(trigger_link_if_i.board_busy), .readout_ack(trigger_link_if_i.readout_ack));
  // ----------------
  // Clock, monitor, tasks
  // ----------------
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  always @(negedge aclk) begin
    if (trigger_link_if_i.link_word[15:12] == 4'h9) begin
      n_str++;
      last_str = trigger_link_if_i.link_word;
    end
    if (trigger_link_if_i.link_word[15:12] == 4'h7) begin
      cw = trigger_link_if_i.link_word;
      n_cw++;
    end
    if (ew4_valid) ew4 = ew4_high;
    n_acc += trigger_accepted;
    trig_seen |= trigger_out;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] rs);
    logic aw, w, b;
    b = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b) begin
      @(negedge aclk);
      aw = awvalid && awready;
      w = wvalid && wready;
      b = bvalid;
      rs = bresp;
      @(posedge aclk);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      if (b) bready <= 1'b0;
    end
  endtask
  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] rs);
    logic ar, b;
    b = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!b) begin
      @(negedge aclk);
      ar = arvalid && arready;
      b = rvalid;
      d = rdata;
      rs = rresp;
      @(posedge aclk);
      if (ar) arvalid <= 1'b0;
      if (b) rready <= 1'b0;
    end
  endtask
  task automatic trig();
    @(posedge aclk) trigger_in <= 1'b1;
    @(posedge aclk) trigger_in <= 1'b0;
    repeat (5) @(posedge aclk);
  endtask
  task automatic ack();
    @(posedge aclk) trigger_link_if_i.readout_ack <= 4'hf;
    @(posedge aclk) trigger_link_if_i.readout_ack <= 4'h0;
    repeat (2) @(negedge aclk);
  endtask
  task automatic wait_busy();
    while (trigger_link_if_i.board_busy !== 4'hf) @(negedge aclk);
    chk(sync_marker, 4'hf);
  endtask
  task automatic rel(input logic [3:0] p);
    @(posedge aclk) block_pending <= p;
    @(posedge aclk) block_pending <= 4'h0;
    ack();
    chk(trigger_link_if_i.board_busy, p);
    ack();
    chk(trigger_link_if_i.board_busy, 4'h0);
    chk(sync_marker, 4'h0);
  endtask
  task automatic rst();
    @(posedge aclk) aresetn <= 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask
  task automatic print_verdict();
    if (n_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    print_verdict();
  end
  // ----------------
  // Sequence
  // ----------------
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, trigger_in, front_panel_sync} = 8'h00;
    {awaddr, araddr, wdata, local_trigger, block_pending, trig_seen, trigger_inputs} = '0;
    buffer_mode = 1'b1;
    trigger_link_if_i.readout_ack = 4'h0;
    rst();
    axi_rd(12'h0d4, q, r);
    chk(q, 32'h0001_0001);
    chk(event_number, 32'h0);
    for (int i = 0; i < 6; i++) begin
      axi_wr(rows[i].a, rows[i].d, r);
      chk(r, rows[i].r);
      axi_rd(rows[i].a, q, r);
      chk(q, rows[i].q);
      chk(r, rows[i].r);
    end
    repeat (3) begin
      @(posedge aclk) local_trigger <= 4'h4;
      @(posedge aclk) local_trigger <= 4'h0;
    end
    trig();
    chk(cw, 16'h7403);
    chk(ew4, 12'h403);
    trig();
    chk(cw, 16'h7000);
    axi_wr(12'h100, 32'h0010_0000, r);
    wait_busy();
    chk(last_str[9:8], 2'h3);
    chk(last_str[5:0], 6'h00);
    a0 = n_acc;
    trig();
    chk(n_acc, a0);
    axi_rd(12'h104, q, r);
    chk(q, 32'h0000_0001);
    axi_rd(12'h100, q, r);
    chk(q, 32'h0);
    rel(4'h1);
    chk(n_str, 3);
    repeat (300) @(posedge aclk);
    trig();
    chk(n_acc, a0 + 1);
    @(posedge aclk) front_panel_sync <= 1'b1;
    repeat (2) @(posedge aclk);
    front_panel_sync <= 1'b0;
    wait_busy();
    chk(last_str[9:8], 2'h3);
    rel(4'h0);
    chk(trig_seen, 4'hf);
    rst();
    axi_wr(12'h200, 32'h3c, r);
    axi_wr(12'h21c, 32'h40, r);
    axi_wr(12'h244, 32'h80, r);
    axi_wr(12'h0d4, 32'h8002_0002, r);
    @(posedge aclk) trigger_inputs <= 8'h38;
    buffer_mode <= 1'b0;
    a0 = n_cw;
    for (int i = 0; i < 4; i++) begin
      trig();
      chk(last_str[9:8] == 2'h3, i == 3);
    end
    chk(last_str[5:0], 6'h3f);
    chk(n_cw, a0);
    chk(event_number, 32'h4);
    wait_busy();
    rel(4'h0);
    repeat (300) @(posedge aclk);
    trig();
    chk(event_number, 32'h5);
    print_verdict();
  end
endmodule
`default_nettype wire
